// ---- hdl/blcp_char_filter.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "blcp_cfg.svh"

module blcp_char_filter (
    blcp_char_if.filt cif
);
    logic upper;
    logic lower;

    // ----------------------------------------
    // Classify and fold case
    // ----------------------------------------
    assign upper = (cif.raw >= 8'h41) && (cif.raw <= 8'h5A);
    assign lower = (cif.raw >= 8'h61) && (cif.raw <= 8'h7A);
    assign cif.ch = lower ? (cif.raw & ~`BLCP_CASE_BIT) : cif.raw; // RQ14
    assign cif.is_letter = upper || lower;
    assign cif.is_digit = (cif.raw >= `BLCP_CH_ZERO) && (cif.raw <= 8'h39);
    assign cif.is_lf = (cif.raw == `BLCP_CH_LF);
    assign cif.is_minus = (cif.raw == `BLCP_CH_MINUS);
    assign cif.is_pct = (cif.raw == `BLCP_CH_PCT);
    // Spaces and anything unlisted never reach the parser
    assign cif.keep = cif.valid && (cif.is_letter || cif.is_digit || cif.is_lf ||
        cif.is_minus || cif.is_pct || (cif.raw == `BLCP_CH_POINT)); // RQ15
endmodule : blcp_char_filter

`default_nettype wire

// ---- hdl/blcp_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module blcp_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // ----------------------------------------
    // Two flops per bit, first one feeds only the second
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_reg;
endmodule : blcp_sync

`default_nettype wire

// ---- hdl/blcp_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "blcp_cfg.svh"

// How it works
// RQ1 - Command bytes only when ATN and not IFC
// RQ2 - Addressed indicator follows listen state always
// RQ3 - Five switches give listen address 0 to 30
// RQ4 - Bytes with ATN false are data
// RQ5 - Data acted on only if remote and listening
// RQ6 - Listening lasts until IFC or unlisten
// RQ7 - String ends on LF, EOI with ATN, internal
// RQ8 - Function value units, or source function value units
// RQ9 - Hertz, protection reset, standby and on codes
// RQ10 - Excess value digits dropped, point and sign counted
// RQ11 - Limit nine wide, two for AM/FM, increment follows
// RQ12 - Point everywhere, minus only for amplitude
// RQ13 - Amplitude leading zeros not counted
// RQ14 - Upper and lower case letters equivalent
// RQ15 - Only letters digits LF hyphen period percent
// RQ16 - No codes for display, tune, backspace keys
// RQ17 - Never talks on the data lines
// RQ18 - Group execute trigger has no effect
// RQ19 - Controller sends addresses, codes, then terminator
// RQ20 - IFC unaddresses at once
// RQ21 - Remote entered on first listen address with REN
// RQ22 - Listen group byte matches switches; all-ones unlistens
module blcp_top
    import blcp_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] dio_n,
    input wire logic atn_n,
    input wire logic ifc_n,
    input wire logic ren_n,
    input wire logic eoi_n,
    input wire logic dav_n,
    input wire logic [4:0] addr_sw,
    output logic nrfd_n_o,
    output logic nrfd_oe,
    output logic ndac_n_o,
    output logic ndac_oe,
    output logic addressed_indicator,
    output logic remote_indicator,
    output logic code_valid,
    output logic [7:0] code_char,
    output logic end_of_string,
    output logic hertz_units_code,
    output logic protection_reset_code,
    output logic standby_code,
    output logic power_on_code
);
    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic [7:0] dio_s;
    logic atn_s;
    logic ifc_s;
    logic ren_s;
    logic eoi_s;
    logic dav_s;
    logic [4:0] addr_s;

    blcp_sync #(.W(18)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in({~dio_n, ~atn_n, ~ifc_n, ~ren_n, ~eoi_n, ~dav_n, addr_sw}),
        .sync_out({dio_s, atn_s, ifc_s, ren_s, eoi_s, dav_s, addr_s})
    );

    function automatic logic [3:0] blcp_len_limit(input blcp_fn_t fn);
        case (fn)
            BLCP_FN_AM, BLCP_FN_FM: blcp_len_limit = `BLCP_LEN_NARROW;
            default: blcp_len_limit = `BLCP_LEN_WIDE;
        endcase
    endfunction : blcp_len_limit

    // ----------------------------------------
    // Acceptor handshake
    // ----------------------------------------
    blcp_hs_t hs_reg;
    logic listen_reg;
    logic remote_reg;
    logic active;
    logic take;

    // Every device accepts commands; data only once addressed
    assign active = atn_s || listen_reg;
    assign take = active && (hs_reg == BLCP_HS_READY) && dav_s;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hs_reg <= BLCP_HS_READY;
        end else if (!active) begin
            hs_reg <= BLCP_HS_READY;
        end else begin
            case (hs_reg)
                BLCP_HS_READY: hs_reg <= dav_s ? BLCP_HS_TAKE : BLCP_HS_READY;
                BLCP_HS_TAKE: hs_reg <= BLCP_HS_HOLD;
                BLCP_HS_HOLD: hs_reg <= dav_s ? BLCP_HS_HOLD : BLCP_HS_READY;
                default: hs_reg <= BLCP_HS_READY;
            endcase
        end
    end

    // Open-drain lines: only ever pulled low, released otherwise
    assign nrfd_n_o = 1'b0;
    assign ndac_n_o = 1'b0;
    assign nrfd_oe = active && (hs_reg != BLCP_HS_READY);
    assign ndac_oe = active && (hs_reg == BLCP_HS_READY);
    // The data lines are inputs only; there is no talker path RQ17

    // ----------------------------------------
    // Command decoding and listener state
    // ----------------------------------------
    logic cmd_take;
    logic is_lag;
    logic is_unl;
    logic is_my;
    logic listen_set;

    assign cmd_take = take && atn_s && !ifc_s; // RQ1
    assign is_lag = (dio_s[6:5] == `BLCP_LAG_TAG);
    assign is_unl = is_lag && (dio_s[4:0] == `BLCP_UNL_LOW); // RQ22
    assign is_my = is_lag && (dio_s[4:0] == addr_s) && (addr_s <= `BLCP_ADDR_MAX); // RQ3
    assign listen_set = cmd_take && is_my && !listen_reg;

    // Bytes outside the listen group, the trigger among them, change nothing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            listen_reg <= 1'b0;
        end else if (ifc_s) begin
            listen_reg <= 1'b0; // RQ20
        end else if (cmd_take) begin // RQ18
            if (is_unl) begin
                listen_reg <= 1'b0; // RQ6
            end else if (is_my) begin
                listen_reg <= 1'b1; // RQ22
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            remote_reg <= 1'b0;
        end else if (!ren_s) begin
            remote_reg <= 1'b0;
        end else if (listen_set) begin
            remote_reg <= 1'b1; // RQ21
        end
    end

    assign addressed_indicator = listen_reg; // RQ2
    assign remote_indicator = remote_reg;

    // ----------------------------------------
    // Data path into the filter
    // ----------------------------------------
    blcp_char_if cif ();
    logic data_take;

    assign data_take = take && !atn_s && listen_reg && remote_reg; // RQ4 RQ5
    assign cif.valid = data_take;
    assign cif.raw = dio_s;

    blcp_char_filter u_filter (
        .cif(cif)
    );

    // ----------------------------------------
    // End of string detection
    // ----------------------------------------
    logic open_reg;
    logic end_q_reg;
    logic end_msg;
    logic int_eos;
    logic eos_now;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            end_q_reg <= 1'b0;
        end else begin
            end_q_reg <= eoi_s && atn_s;
        end
    end

    assign end_msg = eoi_s && atn_s && !end_q_reg && listen_reg && open_reg;
    // Losing the listener mid-string closes the string rather than leaving it hanging
    assign int_eos = open_reg && listen_reg && (ifc_s || (cmd_take && is_unl));
    assign eos_now = (cif.keep && cif.is_lf) || end_msg || int_eos; // RQ7

    // ----------------------------------------
    // Program code parser
    // ----------------------------------------
    // Display, tune and backspace keys have no codes and pass as plain letters RQ16
    blcp_fn_t fn_reg;
    logic [7:0] pend_reg;
    logic pend_vld_reg;
    logic [3:0] cnt_reg;
    logic sig_reg;
    logic code_valid_reg;
    logic [7:0] code_char_reg;
    logic eos_reg;
    logic hz_reg;
    logic rp_reg;
    logic stby_reg;
    logic on_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fn_reg <= BLCP_FN_NONE;
            pend_reg <= `BLCP_RST_CHAR;
            pend_vld_reg <= 1'b0;
            cnt_reg <= `BLCP_RST_CNT;
            sig_reg <= 1'b0;
            open_reg <= 1'b0;
            code_valid_reg <= 1'b0;
            code_char_reg <= `BLCP_RST_CHAR;
            eos_reg <= 1'b0;
            hz_reg <= 1'b0;
            rp_reg <= 1'b0;
            stby_reg <= 1'b0;
            on_reg <= 1'b0;
        end else begin
            code_valid_reg <= 1'b0;
            eos_reg <= 1'b0;
            hz_reg <= 1'b0;
            rp_reg <= 1'b0;
            stby_reg <= 1'b0;
            on_reg <= 1'b0;
            if (eos_now) begin
                eos_reg <= 1'b1; // RQ7
                open_reg <= 1'b0;
                pend_vld_reg <= 1'b0;
                cnt_reg <= `BLCP_RST_CNT;
                sig_reg <= 1'b0;
            end else if (cif.keep) begin
                open_reg <= 1'b1;
                if (cif.is_letter) begin
                    // Any letter closes a value field
                    code_valid_reg <= 1'b1;
                    code_char_reg <= cif.ch;
                    cnt_reg <= `BLCP_RST_CNT;
                    sig_reg <= 1'b0;
                    if (pend_vld_reg) begin
                        pend_vld_reg <= 1'b0;
                        case ({pend_reg, cif.ch}) // RQ8
                            `BLCP_CODE_FR: fn_reg <= BLCP_FN_FREQ;
                            `BLCP_CODE_AP: fn_reg <= BLCP_FN_AMPL;
                            `BLCP_CODE_AM: fn_reg <= BLCP_FN_AM;
                            `BLCP_CODE_FM: fn_reg <= BLCP_FN_FM;
                            `BLCP_CODE_HZ: hz_reg <= 1'b1; // RQ9
                            `BLCP_CODE_RP: rp_reg <= 1'b1; // RQ9
                            default: ;
                        endcase
                    end else begin
                        pend_reg <= cif.ch;
                        pend_vld_reg <= 1'b1;
                    end
                end else if (cif.is_digit && pend_vld_reg && (pend_reg == `BLCP_CH_R)) begin
                    pend_vld_reg <= 1'b0;
                    code_valid_reg <= 1'b1;
                    code_char_reg <= cif.ch;
                    stby_reg <= (cif.ch == `BLCP_CH_ZERO); // RQ9
                    on_reg <= (cif.ch == `BLCP_CH_ONE); // RQ9
                end else if (cif.is_pct) begin
                    pend_vld_reg <= 1'b0;
                    code_valid_reg <= 1'b1;
                    code_char_reg <= cif.ch;
                    cnt_reg <= `BLCP_RST_CNT;
                    sig_reg <= 1'b0;
                end else begin
                    pend_vld_reg <= 1'b0;
                    if (cif.is_minus && (fn_reg != BLCP_FN_AMPL)) begin
                        code_valid_reg <= 1'b0; // RQ12
                    end else if ((fn_reg == BLCP_FN_AMPL) && (cif.ch == `BLCP_CH_ZERO)
                            && !sig_reg) begin
                        code_valid_reg <= 1'b1; // RQ13
                        code_char_reg <= cif.ch;
                    end else if (cnt_reg < blcp_len_limit(fn_reg)) begin // RQ10 RQ11
                        code_valid_reg <= 1'b1;
                        code_char_reg <= cif.ch;
                        cnt_reg <= cnt_reg + 4'h1;
                        sig_reg <= sig_reg || !cif.is_minus;
                    end
                end
            end
        end
    end

    assign code_valid = code_valid_reg;
    assign code_char = code_char_reg;
    assign end_of_string = eos_reg;
    assign hertz_units_code = hz_reg;
    assign protection_reset_code = rp_reg;
    assign standby_code = stby_reg;
    assign power_on_code = on_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence seq_take;
        take;
    endsequence

    sequence seq_hold_off;
        nrfd_oe && !ndac_oe;
    endsequence

    AST_HS_HOLDOFF: assert property (seq_take ##0 active |=> !active or seq_hold_off)
        else $error("ready for data not withdrawn after a byte was taken");

    AST_IFC_DROP: assert property (ifc_s |=> !addressed_indicator) // RQ20
        else $error("still addressed after interface clear");

    AST_MY_ADDR: assert property (cmd_take && is_my && !is_unl |=> addressed_indicator) // RQ22
        else $error("own listen address not taken");

    AST_UNLISTEN: assert property (cmd_take && is_unl |=> !listen_reg) // RQ6
        else $error("still listening after unlisten");

    AST_REMOTE_ENTRY: assert property (listen_set && ren_s |=> remote_indicator) // RQ21
        else $error("remote not entered on first listen address");

    AST_DATA_GATE: assert property (code_valid |-> $past(remote_reg && listen_reg)) // RQ5
        else $error("code emitted while not remote and listening");

    AST_LF_END: assert property (cif.keep && cif.is_lf |=> end_of_string && !code_valid) // RQ7
        else $error("line feed did not end the string");

    AST_LEN_LIMIT: assert property (cnt_reg <= blcp_len_limit(fn_reg)) // RQ11
        else $error("value length above the function limit");

    AST_MINUS_AMPL: assert property (code_valid && (code_char == `BLCP_CH_MINUS)
            |-> $past(fn_reg) == BLCP_FN_AMPL) // RQ12
        else $error("minus sign passed outside amplitude");

    AST_CASE_FOLD: assert property (code_valid |-> !((code_char >= 8'h61)
            && (code_char <= 8'h7A)) && (code_char != 8'h20)) // RQ14
        else $error("lower case or space reached the output");
endmodule : blcp_top

`default_nettype wire

// ---- shared/blcp_cfg.svh ----
`ifndef BLCP_CFG_SVH
`define BLCP_CFG_SVH

// ----------------------------------------
// Command group decoding
// ----------------------------------------
`define BLCP_LAG_TAG 2'b01
`define BLCP_UNL_LOW 5'h1F
`define BLCP_ADDR_MAX 5'h1E

// ----------------------------------------
// Value length limits
// ----------------------------------------
`define BLCP_LEN_WIDE 4'h9
`define BLCP_LEN_NARROW 4'h2

// ----------------------------------------
// Character codes
// ----------------------------------------
`define BLCP_CH_LF 8'h0A
`define BLCP_CH_MINUS 8'h2D
`define BLCP_CH_POINT 8'h2E
`define BLCP_CH_PCT 8'h25
`define BLCP_CH_ZERO 8'h30
`define BLCP_CH_ONE 8'h31
`define BLCP_CH_R 8'h52
`define BLCP_CASE_BIT 8'h20

// ----------------------------------------
// Two-character program codes
// ----------------------------------------
`define BLCP_CODE_FR 16'h4652
`define BLCP_CODE_AP 16'h4150
`define BLCP_CODE_AM 16'h414D
`define BLCP_CODE_FM 16'h464D
`define BLCP_CODE_IS 16'h4953
`define BLCP_CODE_HZ 16'h485A
`define BLCP_CODE_RP 16'h5250

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BLCP_RST_CNT 4'h0
`define BLCP_RST_CHAR 8'h00

`endif

// ---- shared/blcp_char_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface blcp_char_if;
    logic valid;
    logic [7:0] raw;
    logic [7:0] ch;
    logic is_letter;
    logic is_digit;
    logic is_lf;
    logic is_minus;
    logic is_pct;
    logic keep;

    modport filt (input valid, input raw, output ch, output is_letter, output is_digit,
        output is_lf, output is_minus, output is_pct, output keep);
    modport user (output valid, output raw, input ch, input is_letter, input is_digit,
        input is_lf, input is_minus, input is_pct, input keep);
endinterface : blcp_char_if

`default_nettype wire

// ---- shared/blcp_pkg.sv ----
package blcp_pkg;

    // Acceptor handshake, Gray along ready, take, hold
    typedef enum logic [1:0] {
        BLCP_HS_READY = 2'b00,
        BLCP_HS_TAKE = 2'b01,
        BLCP_HS_HOLD = 2'b11
    } blcp_hs_t;

    // Function whose value field is being entered
    typedef enum logic [2:0] {
        BLCP_FN_NONE = 3'b000,
        BLCP_FN_FREQ = 3'b001,
        BLCP_FN_AMPL = 3'b011,
        BLCP_FN_AM = 3'b010,
        BLCP_FN_FM = 3'b110
    } blcp_fn_t;

endpackage : blcp_pkg

// ---- verif/blcp_talker.sv ----
`timescale 1ns/10ps
`default_nettype none

module blcp_talker #(
    parameter logic [4:0] TALK_ADDR = 5'h15
) (
    input wire logic core_clk,
    input wire logic nrfd_oe,
    input wire logic ndac_oe,
    output logic [7:0] dio_n,
    output logic atn_n,
    output logic eoi_n,
    output logic dav_n
);
    localparam int WAIT_MAX = 64;

    initial begin
        dio_n = 8'hFF;
        atn_n = 1'b1;
        eoi_n = 1'b1;
        dav_n = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    // ----------------------------------------
    // Three-wire source handshake
    // ----------------------------------------
    task automatic send_byte(input logic [7:0] b, input logic atn);
        int i;
        step(1);
        atn_n = ~atn;
        i = 0;
        while (nrfd_oe === 1'b1 && i < WAIT_MAX) begin
            step(1);
            i++;
        end
        dio_n = ~b;
        // Lines pass a two-flop synchroniser, so ATN and data settle before DAV
        step(3);
        dav_n = 1'b0;
        step(3);
        i = 0;
        while (ndac_oe !== 1'b0 && i < WAIT_MAX) begin
            step(1);
            i++;
        end
        dav_n = 1'b1;
        // Released lines float back to the pull-up level
        dio_n = 8'hFF;
        i = 0;
        while (nrfd_oe === 1'b1 && i < WAIT_MAX) begin
            step(1);
            i++;
        end
    endtask : send_byte

    task automatic listen(input logic [4:0] addr);
        send_byte({3'b010, TALK_ADDR}, 1'b1);
        send_byte({3'b001, addr}, 1'b1);
    endtask : listen

    task automatic send_str(input string s);
        for (int k = 0; k < s.len(); k++) begin
            send_byte(s[k], 1'b0);
        end
    endtask : send_str

    task automatic eoi_end;
        step(1);
        atn_n = 1'b0;
        eoi_n = 1'b0;
        step(4);
        eoi_n = 1'b1;
        step(2);
    endtask : eoi_end
endmodule : blcp_talker

`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic core_clk;
    logic sys_rst;
    logic ifc_n;
    logic ren_n;
    logic [4:0] addr_sw;
    logic [7:0] dio_n;
    logic atn_n;
    logic eoi_n;
    logic dav_n;
    logic nrfd_oe;
    logic ndac_oe;
    logic nrfd_n_o;
    logic ndac_n_o;
    logic addressed_indicator;
    logic remote_indicator;
    logic code_valid;
    logic [7:0] code_char;
    logic end_of_string;
    logic hertz_units_code;
    logic protection_reset_code;
    logic standby_code;
    logic power_on_code;
    int failures = 0;
    int tests_run = 0;
    int eos_cnt = 0;
    int hz_cnt = 0;
    int rp_cnt = 0;
    int sb_cnt = 0;
    int on_cnt = 0;
    logic [7:0] got[$];

    blcp_top u_blcp_top (.core_clk(core_clk), .sys_rst(sys_rst), .dio_n(dio_n),
        .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n), .eoi_n(eoi_n), .dav_n(dav_n),
        .addr_sw(addr_sw), .nrfd_n_o(nrfd_n_o), .nrfd_oe(nrfd_oe), .ndac_n_o(ndac_n_o),
        .ndac_oe(ndac_oe),
        .addressed_indicator(addressed_indicator), .remote_indicator(remote_indicator),
        .code_valid(code_valid), .code_char(code_char), .end_of_string(end_of_string),
        .hertz_units_code(hertz_units_code), .protection_reset_code(protection_reset_code),
        .standby_code(standby_code), .power_on_code(power_on_code));

    blcp_talker u_blcp_talker (.core_clk(core_clk), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe),
        .dio_n(dio_n), .atn_n(atn_n), .eoi_n(eoi_n), .dav_n(dav_n));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Output monitor
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (code_valid === 1'b1) got.push_back(code_char);
        if (end_of_string === 1'b1) eos_cnt++;
        if (hertz_units_code === 1'b1) hz_cnt++;
        if (protection_reset_code === 1'b1) rp_cnt++;
        if (standby_code === 1'b1) sb_cnt++;
        if (power_on_code === 1'b1) on_cnt++;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic clr;
        got.delete();
        eos_cnt = 0;
        hz_cnt = 0;
        rp_cnt = 0;
        sb_cnt = 0;
        on_cnt = 0;
    endtask : clr

    task automatic chk_chars(input string exp);
        chk("char count", got.size(), exp.len());
        for (int k = 0; k < exp.len(); k++) begin
            if (k < got.size()) chk("code char", got[k], exp[k]);
        end
        got.delete();
    endtask : chk_chars

    task automatic end_of_test;
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk("addressed", addressed_indicator, 1'b0);
        chk("remote", remote_indicator, 1'b0);
        chk("chars", got.size(), 0);
        chk("not ready enable", nrfd_oe, 1'b0);
        chk("not accepted enable", ndac_oe, 1'b0);
        chk("not ready level", nrfd_n_o, 1'b0);
    endtask : t_reset

    task automatic t_address;
        u_blcp_talker.listen(5'h1D);
        chk("addressed", addressed_indicator, 1'b0);
        chk("not accepted enable", ndac_oe, 1'b1);
        chk("not ready enable", nrfd_oe, 1'b0);
        chk("not accepted level", ndac_n_o, 1'b0);
        u_blcp_talker.listen(5'h1E);
        chk("addressed", addressed_indicator, 1'b1);
        chk("remote", remote_indicator, 1'b0);
        u_blcp_talker.send_str("a\n");
        chk_chars("");
        chk("end count", eos_cnt, 0);
        u_blcp_talker.send_byte(8'h08, 1'b1);
        chk("addressed", addressed_indicator, 1'b1);
        u_blcp_talker.send_byte(8'h3F, 1'b1);
        chk("addressed", addressed_indicator, 1'b0);
        // The switches are read live, so a new setting takes effect after the sync delay
        addr_sw = 5'h00;
        cyc(3);
        u_blcp_talker.listen(5'h00);
        chk("addressed", addressed_indicator, 1'b1);
        u_blcp_talker.send_byte(8'h3F, 1'b1);
        chk("addressed", addressed_indicator, 1'b0);
        addr_sw = 5'h1E;
        cyc(3);
    endtask : t_address

    task automatic t_remote;
        ren_n = 1'b0;
        cyc(3);
        u_blcp_talker.listen(5'h1E);
        chk("remote", remote_indicator, 1'b1);
        chk("addressed", addressed_indicator, 1'b1);
    endtask : t_remote

    task automatic t_filter;
        clr();
        // Leading zeros are free but the minus sign is counted
        u_blcp_talker.send_str("ap -000#1234567.8%\n");
        chk_chars("AP-0001234567.%");
        chk("end count", eos_cnt, 1);
    endtask : t_filter

    task automatic t_limits;
        clr();
        u_blcp_talker.send_str("am-12345\n");
        chk_chars("AM12");
        u_blcp_talker.send_str("fM987\n");
        chk_chars("FM98");
        u_blcp_talker.send_str("Fr1234567.89\n");
        chk_chars("FR1234567.8");
        chk("end count", eos_cnt, 3);
    endtask : t_limits

    task automatic t_codes;
        clr();
        u_blcp_talker.send_str("hzRpr0r1\n");
        chk_chars("HZRPR0R1");
        chk("hertz", hz_cnt, 1);
        chk("protection reset", rp_cnt, 1);
        chk("standby", sb_cnt, 1);
        chk("power on", on_cnt, 1);
    endtask : t_codes

    task automatic t_eoi;
        clr();
        u_blcp_talker.send_str("f");
        u_blcp_talker.eoi_end();
        chk("end count", eos_cnt, 1);
        chk_chars("F");
        // Unlisten in mid-string closes the open string
        u_blcp_talker.send_str("a");
        u_blcp_talker.send_byte(8'h3F, 1'b1);
        chk("end count", eos_cnt, 2);
        chk_chars("A");
    endtask : t_eoi

    task automatic t_ifc;
        ifc_n = 1'b0;
        cyc(4);
        chk("addressed", addressed_indicator, 1'b0);
        u_blcp_talker.listen(5'h1E);
        chk("addressed", addressed_indicator, 1'b0);
        ifc_n = 1'b1;
        cyc(3);
        clr();
        u_blcp_talker.send_str("a");
        chk_chars("");
    endtask : t_ifc

    initial begin
        #500000;
        failures++;
        end_of_test();
    end

    initial begin
        sys_rst = 1'b1;
        ifc_n = 1'b1;
        ren_n = 1'b1;
        addr_sw = 5'h1E;
        cyc(5);
        sys_rst = 1'b0;
        cyc(3);
        t_reset();
        t_address();
        t_remote();
        t_filter();
        t_limits();
        t_codes();
        t_eoi();
        t_ifc();
        end_of_test();
    end
endmodule : tb

`default_nettype wire
